// ---- src/maint_bridge_consts.vh ----
`ifndef MAINT_BRIDGE_CONSTS_VH
`define MAINT_BRIDGE_CONSTS_VH

// Stream header fields of the first beat.
`define HDR_TID       63:56
`define HDR_FTYPE     55:52
`define HDR_TTYPE     51:48
`define HDR_PRIO      46:45
`define HDR_CRF       44
`define HDR_SIZE      43:36
`define HDR_ERR       35
`define HDR_XAM       33:32
`define HDR_HOP       31:24
`define HDR_OFF       23:0

// Transaction classes and types.
`define FT_NREAD      4'h2
`define FT_NWRITE     4'h5
`define FT_SWRITE     4'h6
`define FT_MAINT      4'h8
`define FT_RESP       4'hD
`define TT_NREAD      4'h4
`define TT_NWRITE     4'h4
`define TT_NWRITE_R   4'h5
`define TT_MRD_REQ    4'h0
`define TT_MWR_REQ    4'h1
`define TT_MRD_RSP    4'h2
`define TT_MWR_RSP    4'h3
`define TT_RSP_NODATA 4'h0
`define TT_RSP_DATA   4'h8

// Only a single four-byte word is a legal size.
`define SIZE_WORD     8'h03
`define STRB_WORD     4'hF

`define AXI_OKAY      2'h0
`define AXI_SLVERR    2'h2

// Configuration offset windows of the three register slaves.
`define PHY_LO        24'h000100
`define BUF_LO        24'h000200
`define BUF_HI        24'h000400
`define SEL_LOG       3'h1
`define SEL_BUF       3'h2
`define SEL_PHY       3'h4

`endif

// ---- src/maintenance_config_bridge.v ----
// Summary of operation
// R1 - Stream packets keep all header fields and priority, unaltered; the bridge sends responses at request priority plus one, saturating at 3.
// R2 - Suppliers byte-reverse stream data.
// R3 - Flow and response bits ride a packet's first beat.
// R4 - Transport traffic uses the stream format.
// R5 - Registers are 32 bits; only single words move.
// R6 - Reserved offsets complete normally.
// R7 - Read-only writes complete normally, unchanged.
// R8 - Port write goes out after address and data handshakes.
// R9 - Write status returns on the response channel.
// R10 - One write in flight until its response is taken.
// R11 - Write address and data may come in either order.
// R12 - Port read goes out on address handshake; response returns.
// R13 - One read in flight until its response is taken.
// R14 - NREAD or NWRITE hitting the base address is maintenance.
// R15 - Remote accesses go onto the configuration master.
// R16 - A remote write gets a status response.
// R17 - A remote read gets one response with status and data.
// R18 - Each access goes by offset to one of three slaves.
// R19 - The slave answers status, plus data for reads.
// R20 - Responses merge request fields with returned status and data.
// R21 - Responses show success; payload only for good reads.
// R22 - Requests are served without user-side signals.
// R23 - An errored write returns error, registers untouched.
// R24 - Any non-word access gets an error response; the bridge sends nothing back for a non-word NWRITE without response (ttype 4).
// R25 - Nonzero hop byte sends the access remote, count minus one.
// R26 - Two low port address bits are ignored.
`include "maint_bridge_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module maintenance_config_bridge (
   input  wire        sys_clk_in,
   input  wire        arst_n_in,
   input  wire [31:0] maint_awaddr_in,
   input  wire        maint_awvalid_in,
   output wire        maint_awready_out,
   input  wire [31:0] maint_wdata_in,
   input  wire [3:0]  maint_wstrb_in,
   input  wire        maint_wvalid_in,
   output wire        maint_wready_out,
   output wire [1:0]  maint_bresp_out,
   output wire        maint_bvalid_out,
   input  wire        maint_bready_in,
   input  wire [31:0] maint_araddr_in,
   input  wire        maint_arvalid_in,
   output wire        maint_arready_out,
   output wire [31:0] maint_rdata_out,
   output wire [1:0]  maint_rresp_out,
   output wire        maint_rvalid_out,
   input  wire        maint_rready_in,
   input  wire [63:0] rx_tdata_in,
   input  wire        rx_tvalid_in,
   output wire        rx_tready_out,
   input  wire        rx_tlast_in,
   input  wire [31:0] rx_tuser_in,
   output wire [63:0] tx_tdata_out,
   output wire        tx_tvalid_out,
   input  wire        tx_tready_in,
   output wire        tx_tlast_out,
   output wire [31:0] tx_tuser_out,
   output wire [23:0] cfg_awaddr_out,
   output wire [2:0]  cfg_awvalid_out,
   input  wire [2:0]  cfg_awready_in,
   output wire [31:0] cfg_wdata_out,
   output wire [2:0]  cfg_wvalid_out,
   input  wire [2:0]  cfg_wready_in,
   input  wire [5:0]  cfg_bresp_in,
   input  wire [2:0]  cfg_bvalid_in,
   output wire [2:0]  cfg_bready_out,
   output wire [23:0] cfg_araddr_out,
   output wire [2:0]  cfg_arvalid_out,
   input  wire [2:0]  cfg_arready_in,
   input  wire [95:0] cfg_rdata_in,
   input  wire [5:0]  cfg_rresp_in,
   input  wire [2:0]  cfg_rvalid_in,
   output wire [2:0]  cfg_rready_out,
   input  wire [9:0]  lcsba_in,
   input  wire [15:0] local_id_in,
   input  wire [15:0] remote_id_in
);

   localparam S_IDLE       = 4'h0;
   localparam S_BODY       = 4'h1;
   localparam S_CFG_WR     = 4'h2;
   localparam S_CFG_B      = 4'h3;
   localparam S_CFG_RD     = 4'h4;
   localparam S_CFG_R      = 4'h5;
   localparam S_TX_LOAD    = 4'h6;
   localparam S_TX_HDR     = 4'h7;
   localparam S_TX_DATA    = 4'h8;
   localparam S_WAIT       = 4'h9;
   localparam S_WAIT_DRAIN = 4'hA;
   localparam S_RSP_DATA   = 4'hB;
   localparam S_DONE       = 4'hC;

   localparam SRC_RX = 2'h0;
   localparam SRC_WR = 2'h1;
   localparam SRC_RD = 2'h2;

   reg [3:0]  state_reg;
   reg [1:0]  src_reg;
   reg [23:0] off_reg;
   reg [7:0]  hop_reg;
   reg [31:0] data_reg;
   reg        err_reg;
   reg        rd_reg;
   reg        want_reg;
   reg        drop_reg;
   reg        got_reg;
   reg [7:0]  tid_reg;
   reg [7:0]  tid_cnt_reg;
   reg [3:0]  ftype_reg;
   reg [1:0]  prio_reg;
   reg        crf_reg;
   reg [15:0] peer_reg;
   reg        awd_reg;
   reg        wd_reg;
   reg [63:0] tx_data_reg;
   reg        tx_last_reg;
   reg [31:0] tx_user_reg;
   reg        aw_full_reg;
   reg [31:0] aw_addr_reg;
   reg        w_full_reg;
   reg [31:0] w_data_reg;
   reg [3:0]  w_strb_reg;
   reg        ar_full_reg;
   reg [31:0] ar_addr_reg;
   reg        bvalid_reg;
   reg [1:0]  bresp_reg;
   reg        rvalid_reg;
   reg [1:0]  rresp_reg;
   reg [31:0] rdata_reg;

   // R18 - route by offset
   function [2:0] slave_of;
      input [23:0] off;
      begin
         if (off >= `PHY_LO && off < `BUF_LO) begin
            slave_of = `SEL_PHY;
         end else if (off >= `BUF_LO && off < `BUF_HI) begin
            slave_of = `SEL_BUF;
         end else begin
            slave_of = `SEL_LOG;
         end
      end
   endfunction

   // R23 - errored writes skip
   function [3:0] dispatch;
      input drop;
      input err;
      input want;
      input rd;
      begin
         if (drop) begin
            dispatch = S_IDLE;
         end else if (err) begin
            dispatch = want ? S_TX_LOAD : S_IDLE;
         end else begin
            dispatch = rd ? S_CFG_RD : S_CFG_WR;
         end
      end
   endfunction

   function [1:0] pick2;
      input [5:0] v;
      input [2:0] sel;
      integer i;
      begin
         pick2 = 2'h0;
         for (i = 0; i < 3; i = i + 1) begin
            if (sel[i]) begin
               pick2 = v[2*i +: 2];
            end
         end
      end
   endfunction

   function [31:0] pick32;
      input [95:0] v;
      input [2:0]  sel;
      integer i;
      begin
         pick32 = 32'h00000000;
         for (i = 0; i < 3; i = i + 1) begin
            if (sel[i]) begin
               pick32 = v[32*i +: 32];
            end
         end
      end
   endfunction

   wire [3:0]  rx_ft  = rx_tdata_in[`HDR_FTYPE];
   wire [3:0]  rx_tt  = rx_tdata_in[`HDR_TTYPE];
   wire [23:0] rx_off = rx_tdata_in[`HDR_OFF];
   wire        rx_mreq = (rx_ft == `FT_MAINT) &&
                         (rx_tt == `TT_MRD_REQ || rx_tt == `TT_MWR_REQ);
   wire        rx_io = (rx_ft == `FT_NREAD) || (rx_ft == `FT_NWRITE) ||
                       (rx_ft == `FT_SWRITE);
   // R14 - base address hit
   wire        rx_hit = rx_io &&
      ({rx_tdata_in[`HDR_XAM], rx_tdata_in[`HDR_HOP]} == lcsba_in);
   wire        rx_ok_io = (rx_ft == `FT_NREAD && rx_tt == `TT_NREAD) ||
      (rx_ft == `FT_NWRITE &&
       (rx_tt == `TT_NWRITE || rx_tt == `TT_NWRITE_R));
   wire        rx_rd = rx_mreq ? (rx_tt == `TT_MRD_REQ) :
                                 (rx_ft == `FT_NREAD);
   wire        rx_want = !(rx_ft == `FT_NWRITE && rx_tt == `TT_NWRITE);
   wire        rx_drop = !(rx_mreq || rx_hit);
   // R24 - size check
   wire        rx_err = (rx_hit && !rx_ok_io) ||
      (rx_tdata_in[`HDR_SIZE] != `SIZE_WORD) || (!rx_rd && rx_tlast_in);
   wire        rx_is_rsp = rx_ft == `FT_RESP || (rx_ft == `FT_MAINT &&
      (rx_tt == `TT_MRD_RSP || rx_tt == `TT_MWR_RSP));
   wire        rx_match = rx_ft == `FT_MAINT &&
      rx_tt == (rd_reg ? `TT_MRD_RSP : `TT_MWR_RSP) &&
      rx_tdata_in[`HDR_TID] == tid_reg;
   wire [31:0] rx_word = off_reg[2] ? rx_tdata_in[31:0] :
                                      rx_tdata_in[63:32];

   wire [2:0]  sel_w = slave_of(off_reg);
   wire        aw_hs = |(cfg_awvalid_out & cfg_awready_in);
   wire        w_hs  = |(cfg_wvalid_out & cfg_wready_in);
   wire [1:0]  b_resp_w = pick2(cfg_bresp_in, sel_w);
   wire [1:0]  r_resp_w = pick2(cfg_rresp_in, sel_w);
   wire [31:0] r_data_w = pick32(cfg_rdata_in, sel_w);
   wire        from_rx = (src_reg == SRC_RX);
   wire [3:0]  cfg_done_w = from_rx ? (want_reg ? S_TX_LOAD : S_IDLE) :
                                      S_DONE;
   // R16 - responses end remote
   wire [3:0]  after_tx_w = from_rx ? S_IDLE : S_WAIT;

   // R21 - payload only good reads
   wire        has_data_w = from_rx ? (rd_reg && !err_reg) : !rd_reg;
   wire [3:0]  tt_w = !from_rx ? (rd_reg ? `TT_MRD_REQ : `TT_MWR_REQ) :
      (ftype_reg == `FT_MAINT) ? (rd_reg ? `TT_MRD_RSP : `TT_MWR_RSP) :
      (has_data_w ? `TT_RSP_DATA : `TT_RSP_NODATA);
   wire [1:0]  prio_w = !from_rx ? 2'h0 :
                        (prio_reg == 2'h3) ? 2'h3 : prio_reg + 2'h1;
   // R25 - hop count minus one
   wire [7:0]  hop_w = from_rx ? 8'h00 : hop_reg - 8'h01;
   // R20 - response from request
   wire [63:0] hdr_w = {tid_reg, ftype_reg, tt_w, 1'b0, prio_w, crf_reg,
      `SIZE_WORD, err_reg & from_rx, 1'b0, 2'h0, hop_w, off_reg};
   wire [63:0] beat_w = off_reg[2] ? {32'h00000000, data_reg} :
                                     {data_reg, 32'h00000000};

   // R10 - one write in flight
   assign maint_awready_out = !aw_full_reg;
   assign maint_wready_out  = !w_full_reg;
   // R13 - one read in flight
   assign maint_arready_out = !ar_full_reg;
   assign maint_bvalid_out  = bvalid_reg;
   assign maint_bresp_out   = bresp_reg;
   assign maint_rvalid_out  = rvalid_reg;
   assign maint_rresp_out   = rresp_reg;
   assign maint_rdata_out   = rdata_reg;

   // Responses are accepted while waiting; requests stall until idle.
   assign rx_tready_out = (state_reg == S_IDLE) || (state_reg == S_BODY) ||
      (state_reg == S_WAIT_DRAIN) || (state_reg == S_RSP_DATA) ||
      (state_reg == S_WAIT && rx_is_rsp);
   // R4 - stream packets out
   assign tx_tdata_out  = tx_data_reg;
   assign tx_tlast_out  = tx_last_reg;
   assign tx_tuser_out  = tx_user_reg;
   assign tx_tvalid_out = (state_reg == S_TX_HDR) || (state_reg == S_TX_DATA);

   // R15 - requests onto master
   assign cfg_awaddr_out  = off_reg;
   assign cfg_araddr_out  = off_reg;
   assign cfg_wdata_out   = data_reg;
   assign cfg_awvalid_out = (state_reg == S_CFG_WR && !awd_reg) ? sel_w : 3'h0;
   assign cfg_wvalid_out  = (state_reg == S_CFG_WR && !wd_reg) ? sel_w : 3'h0;
   assign cfg_bready_out  = (state_reg == S_CFG_B) ? sel_w : 3'h0;
   assign cfg_arvalid_out = (state_reg == S_CFG_RD) ? sel_w : 3'h0;
   assign cfg_rready_out  = (state_reg == S_CFG_R) ? sel_w : 3'h0;

   // R11 - channels captured independently
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 32'h00000000;
         w_full_reg  <= 1'b0;
         w_data_reg  <= 32'h00000000;
         w_strb_reg  <= 4'h0;
         ar_full_reg <= 1'b0;
         ar_addr_reg <= 32'h00000000;
      end else begin
         if (maint_awvalid_in && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= maint_awaddr_in;
         end
         if (maint_wvalid_in && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= maint_wdata_in;
            w_strb_reg <= maint_wstrb_in;
         end
         if (maint_arvalid_in && !ar_full_reg) begin
            ar_full_reg <= 1'b1;
            ar_addr_reg <= maint_araddr_in;
         end
         if (bvalid_reg && maint_bready_in) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
         end
         if (rvalid_reg && maint_rready_in) begin
            ar_full_reg <= 1'b0;
         end
      end
   end

   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg   <= S_IDLE;
         src_reg     <= SRC_RX;
         off_reg     <= 24'h000000;
         hop_reg     <= 8'h00;
         data_reg    <= 32'h00000000;
         err_reg     <= 1'b0;
         rd_reg      <= 1'b0;
         want_reg    <= 1'b0;
         drop_reg    <= 1'b0;
         got_reg     <= 1'b0;
         tid_reg     <= 8'h00;
         tid_cnt_reg <= 8'h00;
         ftype_reg   <= 4'h0;
         prio_reg    <= 2'h0;
         crf_reg     <= 1'b0;
         peer_reg    <= 16'h0000;
         awd_reg     <= 1'b0;
         wd_reg      <= 1'b0;
         tx_data_reg <= 64'h0000000000000000;
         tx_last_reg <= 1'b0;
         tx_user_reg <= 32'h00000000;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= 2'h0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= 2'h0;
         rdata_reg   <= 32'h00000000;
      end else begin
         if (bvalid_reg && maint_bready_in) begin
            bvalid_reg <= 1'b0;
         end
         if (rvalid_reg && maint_rready_in) begin
            rvalid_reg <= 1'b0;
         end
         case (state_reg)
            S_IDLE: begin
               got_reg  <= 1'b0;
               prio_reg <= 2'h0;
               crf_reg  <= 1'b0;
               // Inbound traffic wins so the link backs up only behind
               // a local access already started; the port can be starved by a flood.
               // R22 - autonomous request intake
               if (rx_tvalid_in) begin
                  src_reg   <= SRC_RX;
                  tid_reg   <= rx_tdata_in[`HDR_TID];
                  ftype_reg <= rx_mreq ? `FT_MAINT : `FT_RESP;
                  prio_reg  <= rx_tdata_in[`HDR_PRIO];
                  crf_reg   <= rx_tdata_in[`HDR_CRF];
                  off_reg   <= {rx_off[23:2], 2'h0};
                  peer_reg  <= rx_tuser_in[31:16];
                  rd_reg    <= rx_rd;
                  want_reg  <= rx_want;
                  drop_reg  <= rx_drop;
                  err_reg   <= rx_err;
                  state_reg <= rx_tlast_in ?
                     dispatch(rx_drop, rx_err, rx_want, rx_rd) : S_BODY;
               // R8 - write after both handshakes
               end else if (aw_full_reg && w_full_reg && !bvalid_reg) begin
                  src_reg   <= SRC_WR;
                  rd_reg    <= 1'b0;
                  ftype_reg <= `FT_MAINT;
                  tid_reg   <= tid_cnt_reg;
                  peer_reg  <= remote_id_in;
                  data_reg  <= w_data_reg;
                  hop_reg   <= aw_addr_reg[31:24];
                  // R26 - drop low bits
                  off_reg   <= {aw_addr_reg[23:2], 2'h0};
                  // R24 - partial strobes refused
                  err_reg   <= (w_strb_reg != `STRB_WORD);
                  state_reg <= (w_strb_reg != `STRB_WORD) ? S_DONE :
                     (aw_addr_reg[31:24] != 8'h00) ? S_TX_LOAD : S_CFG_WR;
               // R12 - read on address
               end else if (ar_full_reg && !rvalid_reg) begin
                  src_reg   <= SRC_RD;
                  rd_reg    <= 1'b1;
                  ftype_reg <= `FT_MAINT;
                  tid_reg   <= tid_cnt_reg;
                  peer_reg  <= remote_id_in;
                  err_reg   <= 1'b0;
                  hop_reg   <= ar_addr_reg[31:24];
                  off_reg   <= {ar_addr_reg[23:2], 2'h0};
                  state_reg <= (ar_addr_reg[31:24] != 8'h00) ? S_TX_LOAD :
                                                             S_CFG_RD;
               end
            end
            S_BODY: begin
               if (rx_tvalid_in) begin
                  got_reg <= 1'b1;
                  // R5 - single word kept
                  if (!got_reg) begin
                     data_reg <= rx_word;
                  end
                  if (rx_tlast_in) begin
                     state_reg <= dispatch(drop_reg, err_reg, want_reg, rd_reg);
                  end
               end
            end
            S_CFG_WR: begin
               if (aw_hs) begin
                  awd_reg <= 1'b1;
               end
               if (w_hs) begin
                  wd_reg <= 1'b1;
               end
               if ((awd_reg || aw_hs) && (wd_reg || w_hs)) begin
                  awd_reg   <= 1'b0;
                  wd_reg    <= 1'b0;
                  state_reg <= S_CFG_B;
               end
            end
            // R19 - slave status returned
            S_CFG_B: begin
               if (|(cfg_bvalid_in & sel_w)) begin
                  // R6 - only slave errors count
                  err_reg   <= b_resp_w[1];
                  state_reg <= cfg_done_w;
               end
            end
            S_CFG_RD: begin
               if (|(cfg_arvalid_out & cfg_arready_in)) begin
                  state_reg <= S_CFG_R;
               end
            end
            S_CFG_R: begin
               if (|(cfg_rvalid_in & sel_w)) begin
                  data_reg  <= r_data_w;
                  err_reg   <= r_resp_w[1];
                  state_reg <= cfg_done_w;
               end
            end
            // R3 - flags on first beat
            S_TX_LOAD: begin
               // R1 - full header emitted
               tx_data_reg <= hdr_w;
               tx_last_reg <= !has_data_w;
               tx_user_reg <= {local_id_in, peer_reg};
               if (!from_rx) begin
                  tid_cnt_reg <= tid_cnt_reg + 8'h01;
               end
               state_reg <= S_TX_HDR;
            end
            S_TX_HDR: begin
               if (tx_tready_in) begin
                  if (has_data_w) begin
                     tx_data_reg <= beat_w;
                     tx_last_reg <= 1'b1;
                     state_reg   <= S_TX_DATA;
                  end else begin
                     state_reg <= after_tx_w;
                  end
               end
            end
            // R17 - single read response
            S_TX_DATA: begin
               if (tx_tready_in) begin
                  state_reg <= after_tx_w;
               end
            end
            // A remote access has no timeout; a lost response stalls port.
            S_WAIT: begin
               got_reg <= 1'b0;
               if (rx_tvalid_in && rx_is_rsp) begin
                  if (rx_match) begin
                     err_reg   <= rx_tdata_in[`HDR_ERR] || (rd_reg && rx_tlast_in);
                     state_reg <= rx_tlast_in ? S_DONE : S_RSP_DATA;
                  end else if (!rx_tlast_in) begin
                     state_reg <= S_WAIT_DRAIN;
                  end
               end
            end
            S_WAIT_DRAIN: begin
               if (rx_tvalid_in && rx_tlast_in) begin
                  state_reg <= S_WAIT;
               end
            end
            S_RSP_DATA: begin
               if (rx_tvalid_in) begin
                  got_reg <= 1'b1;
                  if (rd_reg && !err_reg && !got_reg) begin
                     data_reg <= rx_word;
                  end
                  if (rx_tlast_in) begin
                     state_reg <= S_DONE;
                  end
               end
            end
            // R9 - status to port
            S_DONE: begin
               if (src_reg == SRC_WR) begin
                  bvalid_reg <= 1'b1;
                  bresp_reg  <= err_reg ? `AXI_SLVERR : `AXI_OKAY;
               end else begin
                  rvalid_reg <= 1'b1;
                  rresp_reg  <= err_reg ? `AXI_SLVERR : `AXI_OKAY;
                  rdata_reg  <= data_reg;
               end
               state_reg <= S_IDLE;
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ---- test/cfg_slave_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module cfg_slave_model (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [2:0]  awvalid_in,
   input  wire logic [2:0]  wvalid_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic [2:0]  bready_in,
   input  wire logic [2:0]  arvalid_in,
   input  wire logic [2:0]  rready_in,
   output var  logic [2:0]  bvalid_out,
   output var  logic [2:0]  rvalid_out,
   output var  logic [95:0] rdata_out
);
   // One word per slave, so a misrouted access shows up as wrong data.
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bvalid_out <= 3'h0;
         rvalid_out <= 3'h0;
         rdata_out <= 96'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (awvalid_in[i] && wvalid_in[i]) begin
               rdata_out[32*i+:32] <= wdata_in;
               bvalid_out[i] <= 1'h1;
            end else if (bready_in[i]) bvalid_out[i] <= 1'h0;
            if (arvalid_in[i]) rvalid_out[i] <= 1'h1;
            else if (rready_in[i]) rvalid_out[i] <= 1'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- test/maint_bridge_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module maint_bridge_sva (
   input wire logic        sys_clk_in,
   input wire logic        arst_n_in,
   input wire logic        maint_awready_out,
   input wire logic        maint_wready_out,
   input wire logic        maint_bvalid_out,
   input wire logic        maint_bready_in,
   input wire logic [1:0]  maint_bresp_out,
   input wire logic        maint_arready_out,
   input wire logic        maint_rvalid_out,
   input wire logic        maint_rready_in,
   input wire logic [31:0] maint_rdata_out,
   input wire logic [2:0]  cfg_awvalid_out,
   input wire logic [23:0] cfg_awaddr_out,
   input wire logic [2:0]  cfg_arvalid_out,
   input wire logic [23:0] cfg_araddr_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);
   b_hold_a: assert property (
      maint_bvalid_out && !maint_bready_in |=>
      maint_bvalid_out && $stable(maint_bresp_out)) else $error("bresp lost");
   w_single_a: assert property (
      maint_bvalid_out |-> !maint_awready_out && !maint_wready_out)
      else $error("second write taken");
   r_single_a: assert property (
      maint_rvalid_out |-> !maint_arready_out) else $error("second read taken");
   r_hold_a: assert property (
      maint_rvalid_out && !maint_rready_in |=>
      maint_rvalid_out && $stable(maint_rdata_out)) else $error("rdata lost");
   aw_onehot_a: assert property (
      $onehot0(cfg_awvalid_out)) else $error("two write slaves");
   buf_route_a: assert property (
      (|cfg_awvalid_out) && cfg_awaddr_out[23:9] == 15'h0001 |->
      cfg_awvalid_out == 3'h2) else $error("buffer misrouted");
   phy_route_a: assert property (
      (|cfg_arvalid_out) && cfg_araddr_out[23:8] == 16'h0001 |->
      cfg_arvalid_out == 3'h4) else $error("physical misrouted");
   word_addr_a: assert property (
      (|cfg_arvalid_out) |-> cfg_araddr_out[1:0] == 2'h0)
      else $error("byte bits forwarded");
endmodule
bind maintenance_config_bridge maint_bridge_sva u_sva (.*);
`default_nettype wire

// ---- test/maintenance_config_bridge_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module maintenance_config_bridge_tb;
   logic sys_clk_in, arst_n_in, maint_awvalid_in, maint_wvalid_in;
   logic maint_bready_in, maint_arvalid_in, maint_rready_in, tx_tready_in;
   logic rx_tvalid_in, rx_tlast_in;
   logic [31:0] maint_awaddr_in, maint_wdata_in, maint_araddr_in, rx_tuser_in;
   logic [3:0]  maint_wstrb_in;
   logic [63:0] rx_tdata_in;
   logic [9:0]  lcsba_in;
   logic [15:0] local_id_in, remote_id_in;
   wire maint_awready_out, maint_wready_out, maint_bvalid_out, tx_tlast_out;
   wire maint_arready_out, maint_rvalid_out, rx_tready_out, tx_tvalid_out;
   wire [1:0]  maint_bresp_out, maint_rresp_out;
   wire [31:0] maint_rdata_out, tx_tuser_out, cfg_wdata_out;
   wire [63:0] tx_tdata_out;
   wire [23:0] cfg_awaddr_out, cfg_araddr_out;
   wire [2:0]  cfg_awvalid_out, cfg_wvalid_out, cfg_bready_out, cfg_bvalid_in;
   wire [2:0]  cfg_arvalid_out, cfg_rready_out, cfg_rvalid_in;
   wire [2:0]  cfg_awready_in = 3'h7, cfg_wready_in = 3'h7;
   wire [2:0]  cfg_arready_in = 3'h7;
   wire [5:0]  cfg_bresp_in = 6'h0, cfg_rresp_in = 6'h0;
   wire [95:0] cfg_rdata_in;
   integer err_total = 0, num_checks = 0, cyc = 0;
   maintenance_config_bridge uut (.*);
   cfg_slave_model slaves (.clk_in(sys_clk_in), .rst_n_in(arst_n_in),
      .awvalid_in(cfg_awvalid_out), .wvalid_in(cfg_wvalid_out),
      .wdata_in(cfg_wdata_out), .bready_in(cfg_bready_out),
      .arvalid_in(cfg_arvalid_out), .rready_in(cfg_rready_out),
      .bvalid_out(cfg_bvalid_in), .rvalid_out(cfg_rvalid_in),
      .rdata_out(cfg_rdata_in));
   task end_sim;
      if (err_total == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input [63:0] seen, input [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   // v is {ar,w,aw}; each valid holds until taken.
   task req(input [2:0] v, input [31:0] a, input [31:0] d, input [3:0] s);
      @(posedge sys_clk_in);
      maint_awaddr_in <= a;
      maint_araddr_in <= a;
      maint_wdata_in <= d;
      maint_wstrb_in <= s;
      {maint_arvalid_in, maint_wvalid_in, maint_awvalid_in} <= v;
      @(negedge sys_clk_in);
      while ((v & ~{maint_arready_out, maint_wready_out, maint_awready_out})
             != 3'h0) @(negedge sys_clk_in);
      @(posedge sys_clk_in);
      {maint_arvalid_in, maint_wvalid_in, maint_awvalid_in} <= 3'h0;
   endtask
   task rsp(input rd, input [1:0] e, input [31:0] d);
      @(negedge sys_clk_in);
      while (!(rd ? maint_rvalid_out : maint_bvalid_out)) @(negedge sys_clk_in);
      chk(rd ? maint_rresp_out : maint_bresp_out, e);
      if (rd) chk(maint_rdata_out, d);
      @(posedge sys_clk_in);
      {maint_rready_in, maint_bready_in} <= {rd, !rd};
      @(posedge sys_clk_in);
      {maint_rready_in, maint_bready_in} <= 2'h0;
   endtask
   task s_route;
      for (int i = 0; i < 3; i++) begin
         if (i == 1) req(3'h2, 0, 32'hC0DE0001, 4'hF);
         req(i == 1 ? 3'h1 : 3'h3, {22'h0, i[1:0], 8'h60}, 32'hC0DE0000 + i,
             4'hF);
         rsp(1'h0, 2'h0, 32'h0);
         req(3'h4, {22'h0, i[1:0], 8'h63}, 32'h0, 4'hF);
         rsp(1'h1, 2'h0, 32'hC0DE0000 + i);
      end
   endtask
   task s_strb;
      req(3'h3, 32'h60, 32'hBAD0BAD0, 4'h3);
      rsp(1'h0, 2'h2, 32'h0);
   endtask
   task s_rx;
      @(posedge sys_clk_in);
      rx_tdata_in <= 64'hA580_0030_3000_0060;
      rx_tuser_in <= 32'h0042_0007;
      {rx_tvalid_in, rx_tlast_in} <= 2'h3;
      @(negedge sys_clk_in);
      while (!rx_tready_out) @(negedge sys_clk_in);
      @(posedge sys_clk_in);
      rx_tvalid_in <= 1'h0;
      @(negedge sys_clk_in);
      while (!tx_tvalid_out) @(negedge sys_clk_in);
      chk(tx_tdata_out[63:45], {16'hA582, 3'h1});
      chk(tx_tuser_out, {local_id_in, 16'h0042});
      @(negedge sys_clk_in);
      chk({tx_tvalid_out, tx_tlast_out, tx_tdata_out[63:32]},
          {2'h3, 32'hC0DE0000});
   endtask
   initial begin
      sys_clk_in = 1'h0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_total++;
         end_sim;
      end
   end
   initial begin
      {arst_n_in, maint_awvalid_in, maint_wvalid_in, maint_bready_in} = 4'h0;
      {maint_arvalid_in, maint_rready_in, rx_tvalid_in, rx_tlast_in} = 4'h0;
      {maint_awaddr_in, maint_wdata_in, maint_araddr_in} = 96'h0;
      {rx_tuser_in, rx_tdata_in, maint_wstrb_in} = 100'h0;
      {lcsba_in, local_id_in, remote_id_in, tx_tready_in} = 43'h1_0001_0003;
      repeat (4) @(posedge sys_clk_in);
      arst_n_in <= 1'h1;
      s_route;
      s_strb;
      s_rx;
      end_sim;
   end
endmodule
`default_nettype wire
